// ### locality_access_pkg.sv
// constants and types shared by the locality access arbiter
`default_nettype none

package locality_access_pkg;

  // ----------------------------------------------------------------
  // address map
  // ----------------------------------------------------------------
  localparam int         ADDR_W  = 5;
  localparam int         IDX_LSB = 2;
  localparam int         NUM_LOC = 5;
  localparam logic [2:0] LOC_CNT = 3'h5;

  // ----------------------------------------------------------------
  // field positions of the access control register
  // ----------------------------------------------------------------
  localparam int         BIT_VALID   = 7;
  localparam int         BIT_OWNER   = 5;
  localparam int         BIT_TAKEN   = 4;
  localparam int         BIT_SEIZE   = 3;
  localparam int         BIT_WAITING = 2;
  localparam int         BIT_REQUEST = 1;
  localparam logic [7:0] WRITE_MASK  = 8'h3A;
  localparam logic [4:0] LOC_NONE    = 5'h00;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int         CLK_PERIOD_NS  = 10;
  localparam int         VALID_DELAY_NS = 100;
  localparam int         VALID_CYCLES   = VALID_DELAY_NS / CLK_PERIOD_NS;
  localparam logic [3:0] VALID_CNT_MAX  = 4'(VALID_CYCLES);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic registerValidFlag;
    logic reserved;
    logic ownerFlag;
    logic ownershipTakenFlag;
    logic seize;
    logic otherRequestWaiting;
    logic ownershipRequestBit;
    logic establishment;
  } access_reg_t;

  typedef struct packed {
    logic [4:0] ownerFlag;
    logic [4:0] ownershipTakenFlag;
    logic [4:0] otherRequestWaiting;
    logic [4:0] ownershipRequestBit;
  } arb_state_t;

  typedef enum logic [0:0] {RD_WAIT, RD_ANSWER} rd_state_t;

endpackage

`default_nettype wire

// ### locality_access_arbiter.sv
// locality ownership arbiter with per-locality access control registers
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`default_nettype none

// Contract
// R1 - reads wait until the register valid flag is settled and true
// R2 - valid flag never read as one while other fields are unsettled
// R3 - valid flag rises within the reset timing window
// R4 - reserved bit ignores writes and reads zero
// R5 - owner flag reads one only for the owning locality
// R6 - owner writing one to its owner flag releases ownership
// R7 - on release, highest pending requester becomes owner
// R8 - non-owner with request set writing owner flag cancels request
// R9 - non-owner without request writing owner flag has no effect
// R10 - free device grants a new request within the short timeout
// R11 - queued request granted within the short timeout after release
// R12 - seized owner gets taken flag; writing one clears it
// R13 - seize clears owner flag of every lower priority owner
// R14 - seize leaves request bits of other localities unchanged
// R15 - seizer becomes owner, drops its request, waiting bits cleared if none
// R16 - successful seize aborts the running command
// R17 - seize from equal or lower priority than owner is ignored
// R18 - request write sets waiting bit of every other locality
// R19 - grant with no other requests clears all waiting bits
// R20 - cancel clears waiting bits by count of remaining requests
// R21 - writes to the waiting bit are ignored
// R22 - zero fields are ignored; multi-field writes are ignored
// R23 - request bit set by writing one, cleared at grant, zero ignored
// R24 - fixed field layout of the access control register
// R25 - priority rises with locality number; one register per locality
// R26 - seize reads zero; locality zero seize ignored while owned

module locality_access_arbiter
  import locality_access_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              read,
  input  wire logic              write,
  input  wire logic [3:0]        byteenable,
  input  wire logic [31:0]       writedata,
  output var  logic [31:0]       readdata,
  output var  logic              waitrequest,
  output var  logic [4:0]        ownerMask,
  output var  logic              abortCmd
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // highest set bit wins, matching locality priority
  function automatic logic [2:0] topIndex(input logic [4:0] v);
    logic [2:0] idx;
    idx = 3'h0;
    for (int i = 0; i < NUM_LOC; i++) begin
      if (v[i]) begin
        idx = 3'(i); // R25
      end
    end
    return idx;
  endfunction

  function automatic logic [4:0] locBit(input logic [2:0] i);
    return 5'(5'h01 << i);
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arb_state_t  st;
  arb_state_t  next_st;
  logic        next_abortCmd;
  logic [3:0]  validCnt;
  logic [3:0]  next_validCnt;
  logic        regValid;
  logic        next_regValid;
  rd_state_t   rdState;
  rd_state_t   next_rdState;
  logic [31:0] next_readdata;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic [2:0] locSel;
  logic       locHit;
  logic [4:0] selBit;
  logic       wrEn;
  logic [7:0] fields;
  logic       single;
  logic [2:0] ownerIdx;
  logic       ownedNow;
  logic       grantPending;
  logic       settled;
  logic       seizeOk;
  logic [4:0] remaining;
  access_reg_t view;

  assign locSel   = address[ADDR_W-1:IDX_LSB];
  assign locHit   = (address[IDX_LSB-1:0] == 2'h0) && (locSel < LOC_CNT); // R25
  assign selBit   = locHit ? locBit(locSel) : LOC_NONE;
  assign wrEn     = write && byteenable[0] && locHit;
  // reserved, valid and waiting bits are masked off here
  assign fields   = writedata[7:0] & WRITE_MASK; // R4 R21
  assign single   = $onehot(fields); // R22
  assign ownerIdx = topIndex(st.ownerFlag);
  assign ownedNow = (st.ownerFlag != LOC_NONE);
  assign grantPending = !ownedNow && (st.ownershipRequestBit != LOC_NONE);
  // a pending grant means the owner field is about to change
  assign settled  = regValid && !grantPending; // R1 R2
  // when free any locality may seize, zero included
  assign seizeOk  = !ownedNow || (locSel > ownerIdx); // R17 R26
  assign remaining = st.ownershipRequestBit & ~selBit;

  // ----------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_abortCmd = 1'b0;
    if (wrEn && single) begin
      if (fields[BIT_OWNER]) begin
        if (st.ownerFlag[locSel]) begin
          next_st.ownerFlag = LOC_NONE; // R6
        end else if (st.ownershipRequestBit[locSel]) begin // R9
          next_st.ownershipRequestBit = remaining; // R8
          if (remaining == LOC_NONE) begin
            next_st.otherRequestWaiting = LOC_NONE; // R20
          end else if ($onehot(remaining)) begin
            next_st.otherRequestWaiting = st.otherRequestWaiting & ~remaining; // R20
          end
        end
      end else if (fields[BIT_TAKEN]) begin
        next_st.ownershipTakenFlag = st.ownershipTakenFlag & ~selBit; // R12
      end else if (fields[BIT_SEIZE]) begin
        if (seizeOk) begin
          next_st.ownershipTakenFlag = st.ownershipTakenFlag | st.ownerFlag; // R12 R13
          next_st.ownerFlag = selBit; // R15
          next_st.ownershipRequestBit = remaining; // R14 R15
          if (remaining == LOC_NONE) begin
            next_st.otherRequestWaiting = LOC_NONE; // R15
          end
          next_abortCmd = 1'b1; // R16
        end
      end else if (fields[BIT_REQUEST]) begin
        if (!st.ownerFlag[locSel] && !st.ownershipRequestBit[locSel]) begin
          next_st.ownershipRequestBit = st.ownershipRequestBit | selBit; // R23
          next_st.otherRequestWaiting = st.otherRequestWaiting | ~selBit; // R18
        end
      end
    end else if (grantPending) begin
      // one cycle after release or request; far inside the short timeout
      next_st.ownerFlag = locBit(topIndex(st.ownershipRequestBit)); // R7 R10 R11
      next_st.ownershipRequestBit =
        st.ownershipRequestBit & ~locBit(topIndex(st.ownershipRequestBit)); // R23
      if ($onehot(st.ownershipRequestBit)) begin
        next_st.otherRequestWaiting = LOC_NONE; // R19
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      st       <= '0;
      abortCmd <= 1'b0;
    end else begin
      st       <= next_st;
      abortCmd <= next_abortCmd;
    end
  end

  assign ownerMask = st.ownerFlag;

  // ----------------------------------------------------------------
  // valid flag after reset
  // ----------------------------------------------------------------
  always_comb begin
    next_validCnt = validCnt;
    next_regValid = regValid;
    if (!regValid) begin
      next_validCnt = 4'(validCnt + 4'h1);
      if (validCnt == VALID_CNT_MAX - 4'h1) begin
        next_regValid = 1'b1; // R3
      end
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      validCnt <= 4'h0;
      regValid <= 1'b0;
    end else begin
      validCnt <= next_validCnt;
      regValid <= next_regValid;
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------
  always_comb begin
    view                     = '0; // R4 R26
    view.registerValidFlag   = settled; // R2 R24
    view.ownerFlag           = st.ownerFlag[locSel]; // R5 R24
    view.ownershipTakenFlag  = st.ownershipTakenFlag[locSel];
    view.otherRequestWaiting = st.otherRequestWaiting[locSel];
    view.ownershipRequestBit = st.ownershipRequestBit[locSel];
  end

  always_comb begin
    next_rdState  = rdState;
    next_readdata = readdata;
    case (rdState)
      RD_WAIT: begin
        if (read && settled) begin
          next_rdState  = RD_ANSWER; // R1
          next_readdata = locHit ? {24'h000000, view} : 32'h00000000;
        end
      end
      RD_ANSWER: begin
        next_rdState = RD_WAIT;
      end
      default: begin
        next_rdState = RD_WAIT;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rdState  <= RD_WAIT;
      readdata <= 32'h00000000;
    end else begin
      rdState  <= next_rdState;
      readdata <= next_readdata;
    end
  end

  // writes never stall; reads stretch until the cycle after the register is settled
  assign waitrequest = read && (rdState != RD_ANSWER); // R1

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  localparam int VALID_WAIT = VALID_CYCLES;

  logic relEv;
  logic noReqEv;
  logic reqEv;
  logic seizeEv;
  logic cancelEv;

  assign relEv   = wrEn && single && fields[BIT_OWNER] && st.ownerFlag[locSel];
  assign noReqEv = wrEn && single && fields[BIT_OWNER] && !st.ownerFlag[locSel]
                   && !st.ownershipRequestBit[locSel];
  assign reqEv   = wrEn && single && fields[BIT_REQUEST] && !st.ownerFlag[locSel]
                   && !st.ownershipRequestBit[locSel];
  assign seizeEv = wrEn && single && fields[BIT_SEIZE];
  assign cancelEv = wrEn && single && fields[BIT_OWNER] && !st.ownerFlag[locSel]
                    && st.ownershipRequestBit[locSel];

  a_read_waits_valid: assert property ( // R1
    @(posedge mclk) disable iff (!rstn)
    read && !settled && rdState == RD_WAIT |=> !read || waitrequest)
    else $error("read answered before register settled");

  a_valid_means_settled: assert property ( // R2
    @(posedge mclk) disable iff (!rstn)
    read && !waitrequest && readdata[BIT_VALID] |-> $onehot0(st.ownerFlag) && !grantPending)
    else $error("valid flag returned while fields unsettled");

  a_valid_after_reset: assert property ( // R3
    @(posedge mclk) disable iff (!rstn)
    !regValid |-> ##[1:VALID_WAIT] regValid)
    else $error("valid flag late after reset");

  a_reserved_reads_zero: assert property ( // R4
    @(posedge mclk) disable iff (!rstn)
    read && !waitrequest |-> (readdata[7:0] & 8'h49) == 8'h00)
    else $error("reserved or seize bit read as one");

  a_owner_readback: assert property ( // R5
    @(posedge mclk) disable iff (!rstn)
    read && !waitrequest && locHit |-> readdata[BIT_OWNER] == st.ownerFlag[locSel])
    else $error("owner flag read back wrong");

  a_release_clears: assert property ( // R6
    @(posedge mclk) disable iff (!rstn)
    relEv |=> st.ownerFlag == LOC_NONE)
    else $error("owner release did not clear ownership");

  a_grant_when_free: assert property ( // R10
    @(posedge mclk) disable iff (!rstn)
    grantPending && !wrEn |=> $onehot(st.ownerFlag) && abortCmd == 1'b0)
    else $error("free device did not grant request");

  a_ignore_stray_cancel: assert property ( // R9
    @(posedge mclk) disable iff (!rstn)
    noReqEv |=> $stable(st.ownerFlag) && $stable(st.ownershipRequestBit)
                && $stable(st.otherRequestWaiting))
    else $error("stray owner write changed state");

  a_seize_aborts: assert property ( // R16
    @(posedge mclk) disable iff (!rstn)
    seizeEv && seizeOk |=> abortCmd ##1 (!abortCmd || $past(seizeEv && seizeOk)))
    else $error("seize did not pulse command abort");

  a_seize_low_ignored: assert property ( // R17
    @(posedge mclk) disable iff (!rstn)
    seizeEv && !seizeOk |=> $stable(st.ownerFlag) && !abortCmd)
    else $error("low priority seize took effect");

  a_request_waiting: assert property ( // R18
    @(posedge mclk) disable iff (!rstn)
    reqEv |=> (st.otherRequestWaiting | $past(selBit)) == 5'h1F)
    else $error("request did not flag other localities");

  a_waiting_read_only: assert property ( // R21
    @(posedge mclk) disable iff (!rstn)
    wrEn && writedata[7:0] == 8'h04 && !grantPending |=> $stable(st.otherRequestWaiting))
    else $error("write changed waiting bit");

  a_cancel_drops_request: assert property ( // R8
    @(posedge mclk) disable iff (!rstn)
    cancelEv |=> (st.ownershipRequestBit & $past(selBit)) == LOC_NONE && $stable(st.ownerFlag))
    else $error("cancel left request pending");

  a_request_sets_bit: assert property ( // R23
    @(posedge mclk) disable iff (!rstn)
    reqEv |=> (st.ownershipRequestBit & $past(selBit)) != LOC_NONE)
    else $error("request bit not set");

  a_release_hands_over: assert property ( // R7
    @(posedge mclk) disable iff (!rstn)
    relEv && st.ownershipRequestBit != LOC_NONE ##1 !wrEn
    |=> st.ownerFlag == locBit(topIndex($past(st.ownershipRequestBit))))
    else $error("release did not pass ownership to top requester");

  a_seize_marks_taken: assert property ( // R12 R13 R15
    @(posedge mclk) disable iff (!rstn)
    seizeEv && seizeOk |=> (st.ownershipTakenFlag & $past(st.ownerFlag)) == $past(st.ownerFlag)
                           && st.ownerFlag == $past(selBit))
    else $error("seize did not move ownership or mark taken");

  a_seize_keeps_requests: assert property ( // R14
    @(posedge mclk) disable iff (!rstn)
    seizeEv && seizeOk |=>
    st.ownershipRequestBit == ($past(st.ownershipRequestBit) & ~$past(selBit)))
    else $error("seize changed other request bits");

endmodule // locality_access_arbiter

`default_nettype wire

// ### locality_host_model.sv
// avalon master acting for host software on every locality
`default_nettype none

module locality_host_model
  import locality_access_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              waitrequest,
  input  wire logic [31:0]       readdata,
  output var  logic [ADDR_W-1:0] address,
  output var  logic              read,
  output var  logic              write,
  output var  logic [3:0]        byteenable,
  output var  logic [31:0]       writedata
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    address    = '0;
    read       = 1'b0;
    write      = 1'b0;
    byteenable = 4'h0;
    writedata  = 32'h0;
  end

  // ----------------------------------------------------------------
  // bus cycles
  // ----------------------------------------------------------------
  // byte d written as given, several fields allowed; request held until waitrequest is seen low at a rising edge
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic [3:0] be);
    address    <= a;
    writedata  <= {24'h000000, d};
    byteenable <= be;
    write      <= 1'b1;
    @(posedge mclk);
    while (waitrequest) begin
      @(posedge mclk);
    end
    write <= 1'b0;
    @(posedge mclk);
  endtask

  // read data taken at the same edge that shows waitrequest low
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d, output int n);
    n = 0;
    address <= a;
    read    <= 1'b1;
    @(posedge mclk);
    while (waitrequest) begin
      n++;
      @(posedge mclk);
    end
    d = readdata[7:0];
    read <= 1'b0;
    @(posedge mclk);
  endtask
endmodule // locality_host_model

`default_nettype wire

// ### locality_access_arbiter_tb.sv
// self-checking bench for the locality access arbiter
`default_nettype none

module locality_access_arbiter_tb;
  import locality_access_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;

  logic              mclk;
  logic              rstn = 1'b0;
  logic [ADDR_W-1:0] address;
  logic              read;
  logic              write;
  logic [3:0]        byteenable;
  logic [31:0]       writedata;
  logic [31:0]       readdata;
  logic              waitrequest;
  logic [4:0]        ownerMask;
  logic              abortCmd;
  int                failures  = 0;
  int                tests_run = 0;
  int                cyc       = 0;
  int                aborts    = 0;

  locality_access_arbiter DUT (.mclk(mclk), .rstn(rstn), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .ownerMask(ownerMask), .abortCmd(abortCmd));

  locality_host_model host (.mclk(mclk), .waitrequest(waitrequest), .readdata(readdata),
    .address(address), .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // abort pulse lasts one cycle, so count it mid-cycle
  always @(negedge mclk) if (abortCmd === 1'b1) aborts <= aborts + 1;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      test_done();
    end
  end

  function automatic logic [ADDR_W-1:0] la(input logic [2:0] l);
    return ADDR_W'({l, 2'b00});
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e, input string m);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic rc(input logic [2:0] l, input logic [7:0] e);
    logic [7:0] d;
    int         n;
    host.rd(la(l), d, n);
    chk(d, e, "register image");
  endtask

  task automatic w(input logic [2:0] l, input logic [7:0] d);
    host.wr(la(l), d, 4'hF);
  endtask

  // hold: owner must stay put; else wait a short bounded time for it
  task automatic own(input logic [4:0] e, input bit hold);
    int n;
    for (n = 0; n < 8; n++) begin
      @(negedge mclk);
      if (!hold && ownerMask === e) break;
      if (hold && ownerMask !== e) break;
    end
    chk({3'h0, ownerMask}, {3'h0, e}, "owner mask");
    @(posedge mclk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset_valid();
    logic [7:0] d;
    int         n;
    host.rd(la(3'h0), d, n);
    chk(d, 8'h80, "image after reset");
    chk(8'(n >= VALID_CYCLES), 8'h01, "read not stretched");
    own(5'h00, 1'b1);
  endtask

  task automatic t_grant();
    w(3'h1, 8'h02);
    rc(3'h1, 8'hA0);
    own(5'h02, 1'b0);
    rc(3'h0, 8'h80);
  endtask

  task automatic t_queue();
    w(3'h0, 8'h02);
    w(3'h3, 8'h02);
    own(5'h02, 1'b1);
    rc(3'h0, 8'h86);
    rc(3'h2, 8'h84);
    w(3'h1, 8'h20);
    own(5'h08, 1'b0);
    rc(3'h3, 8'hA4);
    rc(3'h1, 8'h84);
    w(3'h0, 8'h20);
    rc(3'h0, 8'h80);
    rc(3'h2, 8'h80);
    w(3'h2, 8'h20);
    own(5'h08, 1'b1);
  endtask

  task automatic t_seize();
    w(3'h1, 8'h02);
    w(3'h2, 8'h08);
    own(5'h08, 1'b1);
    chk(8'(aborts), 8'h00, "abort on refused seize");
    w(3'h4, 8'h08);
    own(5'h10, 1'b0);
    chk(8'(aborts), 8'h01, "abort pulses");
    rc(3'h3, 8'h94);
    rc(3'h1, 8'h82);
    w(3'h3, 8'h10);
    rc(3'h3, 8'h84);
    w(3'h4, 8'h20);
    own(5'h02, 1'b0);
    rc(3'h3, 8'h80);
    w(3'h0, 8'h08);
    own(5'h02, 1'b1);
    w(3'h1, 8'h20);
    own(5'h00, 1'b0);
  endtask

  task automatic t_filters();
    logic [7:0] d;
    int         n;
    w(3'h2, 8'hC4);
    w(3'h2, 8'h04);
    rc(3'h2, 8'h80);
    w(3'h2, 8'h22);
    own(5'h00, 1'b1);
    host.wr(la(3'h2), 8'h02, 4'h0);
    own(5'h00, 1'b1);
    host.wr(5'h14, 8'h02, 4'hF);
    own(5'h00, 1'b1);
    host.rd(5'h14, d, n);
    chk(d, 8'h00, "unmapped read");
    w(3'h2, 8'h08);
    own(5'h04, 1'b0);
    rc(3'h2, 8'hA0);
    w(3'h2, 8'h20);
    own(5'h00, 1'b0);
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    t_reset_valid();
    t_grant();
    t_queue();
    t_seize();
    t_filters();
    test_done();
  end
endmodule // locality_access_arbiter_tb

`default_nettype wire
